// ---- hdl/ps_sensor_link.sv ----
// Sensor core timing, result pending pin and serial bus target front end.
`timescale 1ns/100ps
// How it works
// - Ready within 25 ms after power-up.
// - Ready within 20 ms after soft reset.
// - Continuous pressure refresh near 2000 Hz.
// - Temperature refreshed every 16 pressure updates.
// - Strap to ground answers address 0x21.
// - Strap resistors select addresses 0x22, 0x23.
// - Pending pin low on new result.
// - Pressure read returns pending pin high.
// - After reset pending low until measurement command.
// - Continuous result every 0.5 ms pulls pin low.
// - Triggered result readable 45 ms after command.
module ps_sensor_link
    import ps_pkg::*;
#(
    parameter int unsigned PU_CYCLES = ps_pkg::POWERUP_CYCLES,
    parameter int unsigned SR_CYCLES = ps_pkg::SOFTRESET_CYCLES,
    parameter int unsigned MEAS_CYCLES = ps_pkg::TRIG_CYCLES,
    parameter int unsigned UPD_CYCLES = ps_pkg::PERIOD_CYCLES,
    parameter int unsigned TEMP_EVERY_N = ps_pkg::TEMP_EVERY
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic bus_clk,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    input wire logic [1:0] strap_code,
    input wire ps_pkg::ps_result_t sample,
    output logic result_pending_n,
    output logic ready
);
    import ps_pkg::*;

    localparam int TW = $clog2(TEMP_EVERY_N);

    typedef enum logic [1:0] {CS_BOOT, CS_IDLE, CS_CONT, CS_TRIG} ps_core_st_t;
    typedef enum logic [2:0] {BS_IDLE, BS_ADDR, BS_WRITE, BS_ACK, BS_READ, BS_MACK} ps_bus_st_t;

    // Core clock domain
    ps_core_st_t state_q, state_d;
    logic boot_arm_q;
    logic [1:0] strap_s;
    logic [1:0] evt_s;
    logic [1:0] evt_seen_q;
    logic cmd_evt, read_evt, soft_rst, meas_cmd, result_evt;
    logic is_start, is_trig, is_stop;
    logic tmr_load, tmr_exp;
    logic [TMR_W-1:0] tmr_val;
    logic [6:0] addr_q;
    logic avail_q, pend_n_q, res_tgl_q;
    logic [TW-1:0] temp_cnt_q;
    ps_result_t result_q;

    // Bus clock domain
    ps_bus_st_t bst_q;
    logic brstn;
    logic scl_s, sda_s, scl_p, sda_p;
    logic ready_b, avail_b, res_tgl_b, res_seen_q;
    logic scl_rise, scl_fall, bus_start, bus_stop;
    logic [3:0] bcnt_q;
    logic [7:0] sh_q;
    logic [7:0] tx_byte;
    logic [2:0] idx_q;
    logic [1:0] wr_cnt_q;
    logic rd_dir_q, mnack_q, ack_addr_q;
    logic cmd_tgl_q, rd_tgl_q;
    logic [15:0] cmd_b_q;
    ps_result_t res_b_q;

    ps_sync #(.W(2), .INIT(2'h0)) u_strap_sync (
        .clk(clk),
        .rstn(rstn),
        .d(strap_code),
        .q(strap_s)
    );

    // Command word is held stable until long after its toggle lands
    ps_sync #(.W(2), .INIT(2'h0)) u_evt_sync (
        .clk(clk),
        .rstn(rstn),
        .d({cmd_tgl_q, rd_tgl_q}),
        .q(evt_s)
    );

    ps_timer #(.W(TMR_W)) u_tmr (
        .clk(clk),
        .rstn(rstn),
        .load(tmr_load),
        .load_val(tmr_val),
        .expired(tmr_exp)
    );

    always_ff @(posedge clk) begin
        if (!rstn) begin
            evt_seen_q <= 2'h0;
        end else begin
            evt_seen_q <= evt_s;
        end
    end

    assign cmd_evt = evt_s[1] ^ evt_seen_q[1];
    assign read_evt = evt_s[0] ^ evt_seen_q[0];
    assign is_start = (cmd_b_q == CMD_START_CONT) || (cmd_b_q == CMD_START_CONT_AVG);
    assign is_trig = (cmd_b_q == CMD_TRIGGER);
    assign is_stop = (cmd_b_q == CMD_STOP_CONT);
    assign soft_rst = cmd_evt && (cmd_b_q == CMD_SOFT_RESET) && (state_q != CS_BOOT);
    assign meas_cmd = cmd_evt && (state_q == CS_IDLE) && (is_start || is_trig);

    always_comb begin
        state_d = state_q;
        tmr_load = 1'b0;
        tmr_val = TMR_W'(UPD_CYCLES);
        result_evt = 1'b0;
        unique case (state_q)
            CS_BOOT: begin
                if (boot_arm_q) begin
                    tmr_load = 1'b1;
                    tmr_val = TMR_W'(PU_CYCLES);
                end else if (tmr_exp) begin
                    state_d = CS_IDLE;
                end
            end
            CS_IDLE: begin
                if (meas_cmd && is_start) begin
                    tmr_load = 1'b1;
                    state_d = CS_CONT;
                end else if (meas_cmd) begin
                    tmr_load = 1'b1;
                    tmr_val = TMR_W'(MEAS_CYCLES);
                    state_d = CS_TRIG;
                end
            end
            CS_CONT: begin
                if (cmd_evt && is_stop) begin
                    state_d = CS_IDLE;
                end else if (tmr_exp) begin
                    result_evt = 1'b1;
                    tmr_load = 1'b1;
                end
            end
            CS_TRIG: begin
                if (tmr_exp) begin
                    result_evt = 1'b1;
                    state_d = CS_IDLE;
                end
            end
        endcase
        if (soft_rst) begin
            state_d = CS_BOOT;
            tmr_load = 1'b1;
            tmr_val = TMR_W'(SR_CYCLES);
            result_evt = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            state_q <= CS_BOOT;
            boot_arm_q <= 1'b1;
            ready <= 1'b0;
        end else begin
            state_q <= state_d;
            boot_arm_q <= 1'b0;
            ready <= (state_d != CS_BOOT);
        end
    end

    // Strap read only while initialising; a pin tied high is not allowed
    always_ff @(posedge clk) begin
        if (!rstn) begin
            addr_q <= ADDR_GND;
        end else if (state_q == CS_BOOT) begin
            case (strap_s)
                STRAP_GND: addr_q <= ADDR_GND;
                STRAP_R1K2: addr_q <= ADDR_R1K2;
                STRAP_R2K7: addr_q <= ADDR_R2K7;
                default: addr_q <= ADDR_GND;
            endcase
        end
    end

    // New result wins over a read that lands in the same cycle
    always_ff @(posedge clk) begin
        if (!rstn) begin
            pend_n_q <= 1'b0;
        end else if (soft_rst || result_evt) begin
            pend_n_q <= 1'b0;
        end else if (state_q != CS_BOOT && (read_evt || meas_cmd)) begin
            pend_n_q <= 1'b1;
        end
    end

    assign result_pending_n = pend_n_q;

    // Reads are refused until a result exists and while a trigger runs
    always_ff @(posedge clk) begin
        if (!rstn) begin
            avail_q <= 1'b0;
        end else if (soft_rst || (meas_cmd && is_trig)) begin
            avail_q <= 1'b0;
        end else if (result_evt) begin
            avail_q <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            result_q <= '0;
            temp_cnt_q <= '0;
            res_tgl_q <= 1'b0;
        end else if (meas_cmd) begin
            temp_cnt_q <= '0;
        end else if (result_evt) begin
            result_q.pressure <= sample.pressure;
            if (temp_cnt_q == '0 || state_q == CS_TRIG) begin
                result_q.temp <= sample.temp;
            end
            temp_cnt_q <= (temp_cnt_q == TW'(TEMP_EVERY_N - 1)) ? '0 : temp_cnt_q + 1'b1;
            res_tgl_q <= ~res_tgl_q;
        end
    end

    // Bus front end
    ps_sync #(.W(1), .INIT(1'b0)) u_brst_sync (
        .clk(bus_clk),
        .rstn(1'b1),
        .d(rstn),
        .q(brstn)
    );

    // Oversampling is safe only while the host stays at or below the clock limit
    ps_sync #(.W(2), .INIT(2'h3)) u_pin_sync (
        .clk(bus_clk),
        .rstn(brstn),
        .d({scl_i, sda_i}),
        .q({scl_s, sda_s})
    );

    ps_sync #(.W(3), .INIT(3'h0)) u_stat_sync (
        .clk(bus_clk),
        .rstn(brstn),
        .d({ready, avail_q, res_tgl_q}),
        .q({ready_b, avail_b, res_tgl_b})
    );

    always_ff @(posedge bus_clk) begin
        if (!brstn) begin
            scl_p <= 1'b1;
            sda_p <= 1'b1;
        end else begin
            scl_p <= scl_s;
            sda_p <= sda_s;
        end
    end

    assign scl_rise = scl_s && !scl_p;
    assign scl_fall = !scl_s && scl_p;
    assign bus_start = scl_s && scl_p && sda_p && !sda_s;
    assign bus_stop = scl_s && scl_p && !sda_p && sda_s;

    // Snapshot is frozen from the read acknowledge on, so one read never mixes two results
    always_ff @(posedge bus_clk) begin
        if (!brstn) begin
            res_b_q <= '0;
            res_seen_q <= 1'b0;
        end else if (res_tgl_b != res_seen_q && bst_q != BS_READ && bst_q != BS_MACK
                && !(bst_q == BS_ACK && rd_dir_q)) begin
            res_b_q <= result_q;
            res_seen_q <= res_tgl_b;
        end
    end

    always_comb begin
        unique case (idx_q)
            3'h0: tx_byte = res_b_q.pressure[15:8];
            3'h1: tx_byte = res_b_q.pressure[7:0];
            3'h2: tx_byte = res_b_q.temp[15:8];
            3'h3: tx_byte = res_b_q.temp[7:0];
            default: tx_byte = BYTE_FILL;
        endcase
    end

    always_ff @(posedge bus_clk) begin
        if (!brstn) begin
            bst_q <= BS_IDLE;
            bcnt_q <= 4'h0;
            sh_q <= 8'h00;
            idx_q <= 3'h0;
            wr_cnt_q <= 2'h0;
            rd_dir_q <= 1'b0;
            mnack_q <= 1'b0;
            ack_addr_q <= 1'b0;
            cmd_tgl_q <= 1'b0;
            rd_tgl_q <= 1'b0;
            cmd_b_q <= 16'h0000;
        end else if (bus_start) begin
            bst_q <= BS_ADDR;
            bcnt_q <= 4'h0;
            idx_q <= 3'h0;
            wr_cnt_q <= 2'h0;
            ack_addr_q <= 1'b0;
        end else if (bus_stop) begin
            bst_q <= BS_IDLE;
            ack_addr_q <= 1'b0;
            wr_cnt_q <= 2'h0;
            if (wr_cnt_q == CMD_BYTES) begin
                cmd_tgl_q <= ~cmd_tgl_q;
            end
        end else begin
            unique case (bst_q)
                BS_IDLE: begin
                end
                BS_ADDR, BS_WRITE: begin
                    if (scl_rise) begin
                        sh_q <= {sh_q[6:0], sda_s};
                        bcnt_q <= bcnt_q + 1'b1;
                    end else if (scl_fall && bcnt_q == BYTE_BITS) begin
                        bcnt_q <= 4'h0;
                        if (bst_q == BS_ADDR) begin
                            if (ready_b && sh_q[7:1] == addr_q && (!sh_q[0] || avail_b)) begin
                                bst_q <= BS_ACK;
                                rd_dir_q <= sh_q[0];
                                ack_addr_q <= 1'b1;
                            end else begin
                                bst_q <= BS_IDLE;
                            end
                        end else begin
                            bst_q <= BS_ACK;
                            rd_dir_q <= 1'b0;
                            if (wr_cnt_q == 2'h0) begin
                                cmd_b_q[15:8] <= sh_q;
                            end else if (wr_cnt_q == 2'h1) begin
                                cmd_b_q[7:0] <= sh_q;
                            end
                            if (wr_cnt_q != CMD_BYTES) begin
                                wr_cnt_q <= wr_cnt_q + 1'b1;
                            end
                        end
                    end
                end
                BS_ACK: begin
                    if (scl_fall) begin
                        ack_addr_q <= 1'b0;
                        if (rd_dir_q) begin
                            bst_q <= BS_READ;
                            sh_q <= tx_byte;
                        end else begin
                            bst_q <= BS_WRITE;
                        end
                    end
                end
                BS_READ: begin
                    if (scl_rise) begin
                        bcnt_q <= bcnt_q + 1'b1;
                    end else if (scl_fall && bcnt_q == BYTE_BITS) begin
                        bst_q <= BS_MACK;
                        bcnt_q <= 4'h0;
                        if (idx_q == PRESS_LSB_IDX) begin
                            rd_tgl_q <= ~rd_tgl_q;
                        end
                        if (idx_q != RD_IDX_LAST) begin
                            idx_q <= idx_q + 1'b1;
                        end
                    end else if (scl_fall) begin
                        sh_q <= {sh_q[6:0], 1'b1};
                    end
                end
                BS_MACK: begin
                    if (scl_rise) begin
                        mnack_q <= sda_s;
                    end else if (scl_fall) begin
                        if (mnack_q) begin
                            bst_q <= BS_IDLE;
                        end else begin
                            bst_q <= BS_READ;
                            sh_q <= tx_byte;
                        end
                    end
                end
            endcase
        end
    end

    // Open drain: only ever pull low
    assign sda_o = 1'b0;
    assign sda_oe = (bst_q == BS_ACK) || (bst_q == BS_READ && !sh_q[7]);

    // Checks
    logic [TMR_W-1:0] boot_cnt_q, gap_q;
    logic sr_boot_q;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            boot_cnt_q <= '0;
            gap_q <= '0;
            sr_boot_q <= 1'b0;
        end else begin
            boot_cnt_q <= (state_d == CS_BOOT && !soft_rst) ? boot_cnt_q + 1'b1 : '0;
            gap_q <= (tmr_load || result_evt) ? '0 : gap_q + 1'b1;
            if (soft_rst) begin
                sr_boot_q <= 1'b1;
            end
        end
    end

    a_powerup_ready: assert property (@(posedge clk) disable iff (!rstn)
        (state_q == CS_BOOT && !sr_boot_q) |-> boot_cnt_q <= TMR_W'(PU_CYCLES))
        else $error("power-up ready delay exceeded");
    a_softrst_ready: assert property (@(posedge clk) disable iff (!rstn)
        (state_q == CS_BOOT && sr_boot_q) |-> boot_cnt_q <= TMR_W'(SR_CYCLES))
        else $error("soft reset ready delay exceeded");
    a_update_period: assert property (@(posedge clk) disable iff (!rstn)
        (result_evt && state_q == CS_CONT) |-> gap_q == TMR_W'(UPD_CYCLES - 1))
        else $error("continuous update period wrong");
    a_temp_refresh: assert property (@(posedge clk) disable iff (!rstn)
        (result_evt && temp_cnt_q == '0) |=> result_q.temp == $past(sample.temp))
        else $error("temperature not refreshed");
    a_addr_default: assert property (@(posedge clk) disable iff (!rstn)
        (state_q == CS_BOOT && strap_s == STRAP_GND) |=> addr_q == ADDR_GND)
        else $error("default address not selected");
    a_addr_resistor: assert property (@(posedge clk) disable iff (!rstn)
        (state_q == CS_BOOT && strap_s != STRAP_GND && strap_s != 2'h3) |=>
        addr_q == (($past(strap_s) == STRAP_R1K2) ? ADDR_R1K2 : ADDR_R2K7))
        else $error("strap address wrong");
    a_pending_result: assert property (@(posedge clk) disable iff (!rstn)
        result_evt |=> !result_pending_n [*2])
        else $error("pending pin not low after result");
    a_read_release: assert property (@(posedge clk) disable iff (!rstn)
        (read_evt && !result_evt && !soft_rst && state_q != CS_BOOT) |=> result_pending_n)
        else $error("pending pin not released by read");
    a_boot_pending: assert property (@(posedge clk) disable iff (!rstn)
        (state_q == CS_BOOT) |=> !result_pending_n)
        else $error("pending pin high during init");
    a_trig_latency: assert property (@(posedge clk) disable iff (!rstn)
        (result_evt && state_q == CS_TRIG) |-> gap_q == TMR_W'(MEAS_CYCLES - 1))
        else $error("triggered result latency wrong");
    a_ack_own_addr: assert property (@(posedge bus_clk) disable iff (!brstn)
        (bst_q == BS_ACK && ack_addr_q) |-> sh_q[7:1] == addr_q)
        else $error("acknowledged a foreign address");
    a_ack_needs_ready: assert property (@(posedge bus_clk) disable iff (!brstn)
        (bst_q == BS_ACK && ack_addr_q) |-> ready_b)
        else $error("acknowledged before ready");

    c_cont_result: cover property (@(posedge clk) disable iff (!rstn)
        result_evt && state_q == CS_CONT);
    c_trig_result: cover property (@(posedge clk) disable iff (!rstn)
        result_evt && state_q == CS_TRIG);
    c_soft_reset: cover property (@(posedge clk) disable iff (!rstn) soft_rst);
    c_bus_read: cover property (@(posedge bus_clk) disable iff (!brstn)
        bst_q == BS_ACK && ack_addr_q && rd_dir_q);
endmodule // ps_sensor_link

// ---- hdl/ps_pkg.sv ----
// Shared constants, timing figures and carrier types for the pressure sensor link.
package ps_pkg;

    // Core clock rate
    localparam int unsigned CLK_KHZ = 250000;

    // Ready delays, measurement time and update rate
    localparam int unsigned POWERUP_READY_TIME_MS = 25;
    localparam int unsigned SOFTRESET_READY_TIME_MS = 20;
    localparam int unsigned TRIG_MEAS_TIME_MS = 45;
    localparam int unsigned UPDATE_RATE_HZ = 2000;
    localparam int unsigned UPDATE_RATE_MIN_HZ = 1800;
    localparam int unsigned UPDATE_RATE_MAX_HZ = 2200;
    localparam int unsigned TEMP_EVERY = 16;
    localparam int unsigned BUS_SCL_TYP_KHZ = 400;
    localparam int unsigned BUS_SCL_MAX_KHZ = 1000;

    // Longest times round down to whole cycles
    localparam int unsigned POWERUP_CYCLES = POWERUP_READY_TIME_MS * CLK_KHZ;
    localparam int unsigned SOFTRESET_CYCLES = SOFTRESET_READY_TIME_MS * CLK_KHZ;
    localparam int unsigned TRIG_CYCLES = TRIG_MEAS_TIME_MS * CLK_KHZ;
    localparam int unsigned PERIOD_CYCLES = (CLK_KHZ * 1000) / UPDATE_RATE_HZ;
    localparam int unsigned TMR_W = 24;

    // Bus addresses and strap codes from the resistor sense
    localparam int unsigned ADDR_W = 7;
    localparam logic [6:0] ADDR_GND = 7'h21;
    localparam logic [6:0] ADDR_R1K2 = 7'h22;
    localparam logic [6:0] ADDR_R2K7 = 7'h23;
    localparam logic [1:0] STRAP_GND = 2'h0;
    localparam logic [1:0] STRAP_R1K2 = 2'h1;
    localparam logic [1:0] STRAP_R2K7 = 2'h2;

    // Commands
    localparam logic [15:0] CMD_START_CONT = 16'h361E;
    localparam logic [15:0] CMD_START_CONT_AVG = 16'h3615;
    localparam logic [15:0] CMD_STOP_CONT = 16'h3FF9;
    localparam logic [15:0] CMD_TRIGGER = 16'h362F;
    localparam logic [15:0] CMD_SOFT_RESET = 16'h0006;

    // Serial framing
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [1:0] CMD_BYTES = 2'h2;
    localparam logic [2:0] PRESS_LSB_IDX = 3'h1;
    localparam logic [2:0] RD_IDX_LAST = 3'h4;
    localparam logic [7:0] BYTE_FILL = 8'hFF;

    typedef struct packed {
        logic [15:0] pressure;
        logic [15:0] temp;
    } ps_result_t;

endpackage

// ---- hdl/ps_sync.sv ----
// Two flip-flop synchroniser for levels and toggles.
`timescale 1ns/100ps
module ps_sync #(
    parameter int unsigned W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_q;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            meta_q <= INIT;
            q <= INIT;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule // ps_sync

// ---- hdl/ps_timer.sv ----
// Loadable down counter that flags the last cycle of a programmed interval.
`timescale 1ns/100ps
module ps_timer #(
    parameter int unsigned W = 24
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic load,
    input wire logic [W-1:0] load_val,
    output logic expired
);
    logic [W-1:0] cnt_q;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            cnt_q <= '0;
        end else if (load) begin
            cnt_q <= load_val;
        end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - 1'b1;
        end
    end

    // Fires load_val cycles after the load
    assign expired = (cnt_q == W'(1));
endmodule // ps_timer

// ---- test/ps_host_model.sv ----
// Bus master model driving the serial clock and open-drain data line.
`timescale 1ns/100ps
module ps_host_model (
    output logic scl,
    output wire sda,
    input wire logic sda_oe
);
    // Quarter bit of 250 ns keeps the serial clock at 1000 kHz
    localparam int Q = 250;
    logic low_q = 1'b0;
    // Pull-up: the line is high unless a party pulls it low
    assign sda = (low_q || sda_oe) ? 1'b0 : 1'b1;
    initial scl = 1'b1;
    task automatic start();
        low_q = 1'b0;
        #Q scl = 1'b1;
        #Q low_q = 1'b1;
        #Q scl = 1'b0;
        #Q;
    endtask
    task automatic stop();
        low_q = 1'b1;
        #Q scl = 1'b1;
        #Q low_q = 1'b0;
        #Q;
    endtask
    task automatic xfer(input logic [7:0] d, input logic rd, input logic last,
                        output logic [7:0] q, output logic ack);
        for (int i = 7; i >= -1; i--) begin
            low_q = (i < 0) ? (rd && !last) : (!rd && !d[i]);
            #Q scl = 1'b1;
            #Q;
            if (i >= 0) q[i] = sda;
            else ack = !sda;
            #Q scl = 1'b0;
            #Q;
        end
    endtask
endmodule // ps_host_model

// ---- test/tb_top.sv ----
// Self-checking bench for the sensor link against a bus master model.
`timescale 1ns/100ps
module tb_top;
    import ps_pkg::*;
    localparam int PU = 3000;
    localparam int SR = 1500;
    localparam int MEAS = 5000;
    localparam int UPD = 8000;
    logic clk = 1'b0;
    logic bus_clk = 1'b0;
    logic rstn = 1'b0;
    logic [1:0] strap_code = STRAP_R1K2;
    ps_result_t sample = '{pressure: 16'hA5C3, temp: 16'h3C5A};
    logic scl;
    logic sda_o;
    logic sda_oe;
    logic result_pending_n;
    logic ready;
    wire sda;
    int fails = 0;
    int checks = 0;
    initial forever #2 clk = ~clk;
    initial begin
        #1.3;
        forever #6 bus_clk = ~bus_clk;
    end
    ps_host_model host (.scl(scl), .sda(sda), .sda_oe(sda_oe));
    ps_sensor_link #(.PU_CYCLES(PU), .SR_CYCLES(SR), .MEAS_CYCLES(MEAS),
        .UPD_CYCLES(UPD), .TEMP_EVERY_N(16)) uut (.clk(clk), .rstn(rstn),
        .bus_clk(bus_clk), .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
        .strap_code(strap_code), .sample(sample), .result_pending_n(result_pending_n),
        .ready(ready));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test();
        if (fails == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // Bounded wait on ready or on the pending pin
    task automatic wait_lvl(input logic pend, input logic lvl, input int bound);
        int n;
        n = 0;
        while ((pend ? result_pending_n : ready) !== lvl) begin
            @(negedge clk);
            n++;
            if (n > bound) begin
                check(16'h0000, 16'h0001);
                finish_test();
            end
        end
    endtask
    // A zero code sends the address alone
    task automatic cmd(input logic [6:0] a, input logic [15:0] c, output logic ack);
        logic [7:0] q;
        logic k;
        host.start();
        host.xfer({a, 1'b0}, 1'b0, 1'b0, q, ack);
        if (ack && c != 16'h0000) begin
            host.xfer(c[15:8], 1'b0, 1'b0, q, k);
            host.xfer(c[7:0], 1'b0, 1'b0, q, k);
        end
        host.stop();
        repeat (20) @(negedge clk);
    endtask
    task automatic rd(input logic [6:0] a, output logic ack, output logic [15:0] p);
        logic [7:0] q;
        logic k;
        host.start();
        host.xfer({a, 1'b1}, 1'b0, 1'b0, q, ack);
        if (ack) begin
            host.xfer(8'hFF, 1'b1, 1'b0, p[15:8], k);
            host.xfer(8'hFF, 1'b1, 1'b1, p[7:0], k);
        end
        host.stop();
        repeat (20) @(negedge clk);
    endtask
    task automatic t_boot();
        logic a;
        check(result_pending_n, 1'b0);
        cmd(ADDR_R1K2, 16'h0000, a);
        check(a, 1'b0);
        check({sda_o, sda_oe}, 2'h0);
        check(ready, 1'b0);
        wait_lvl(1'b0, 1'b1, PU);
        repeat (10) @(negedge clk);
        cmd(ADDR_GND, 16'h0000, a);
        check(a, 1'b0);
        check(result_pending_n, 1'b0);
    endtask
    task automatic t_cont();
        logic a;
        logic [15:0] p;
        cmd(ADDR_R1K2, CMD_START_CONT, a);
        check(a, 1'b1);
        check(result_pending_n, 1'b1);
        wait_lvl(1'b1, 1'b0, UPD);
        rd(ADDR_R1K2, a, p);
        check(a, 1'b1);
        check(p, sample.pressure);
        check(result_pending_n, 1'b1);
        wait_lvl(1'b1, 1'b0, UPD);
    endtask
    task automatic t_trig();
        logic a;
        logic [15:0] p;
        cmd(ADDR_R1K2, CMD_STOP_CONT, a);
        cmd(ADDR_R1K2, CMD_TRIGGER, a);
        check(a, 1'b1);
        check(result_pending_n, 1'b1);
        rd(ADDR_R1K2, a, p);
        check(a, 1'b0);
        wait_lvl(1'b1, 1'b0, MEAS);
        rd(ADDR_R1K2, a, p);
        check(a, 1'b1);
        check(p, sample.pressure);
        check(result_pending_n, 1'b1);
    endtask
    // Strap moves only take effect at the next soft reset
    task automatic t_strap();
        logic a;
        logic [6:0] cur;
        logic [6:0] adr [3];
        adr = '{ADDR_GND, ADDR_R1K2, ADDR_R2K7};
        cur = ADDR_R1K2;
        for (int s = 0; s < 3; s++) begin
            strap_code = s[1:0];
            cmd(cur, CMD_SOFT_RESET, a);
            check(a, 1'b1);
            check(ready, 1'b0);
            check(result_pending_n, 1'b0);
            wait_lvl(1'b0, 1'b1, SR);
            repeat (10) @(negedge clk);
            // The last pass also starts averaged continuous mode
            cmd(adr[s], (s == 2) ? CMD_START_CONT_AVG : 16'h0000, a);
            check(a, 1'b1);
            if (s == 2) check(result_pending_n, 1'b1);
            cur = adr[s];
        end
    endtask
    initial begin
        repeat (12) @(negedge clk);
        rstn = 1'b1;
        t_boot();
        t_cont();
        t_trig();
        t_strap();
        finish_test();
    end
endmodule // tb_top
